/* spkcr_mcu_model.sv */
`timescale 1ns/100ps
module spkcr_mcu_model #(
   parameter int HALF_NS = 400
)
(
   // serial control pins
   output logic data_o,
   output logic strobe_o,
   output logic drdy_n_o
);
   import spkcr_pkg::*;

   // strobe stands low between frames
   initial
   begin
      data_o   = 1'b0;
      strobe_o = 1'b0;
      drdy_n_o = 1'b1;
   end

   task automatic pulse();
      #(HALF_NS) strobe_o = 1'b1;
      #(HALF_NS) strobe_o = 1'b0;
   endtask : pulse

   task automatic send_word(input spkcr_pkg::spkcr_word_t word);
      drdy_n_o = 1'b0;
      for (int i = WORD_W - 1; i >= 0; i--)
      begin
         // msb first, data settled half a period before the rise
         data_o = word[i];
         pulse();
      end
      drdy_n_o = 1'b1;
      for (int i = 0; i < LATCH_PULSES; i++)
      begin
         // data no longer meaningful, so it is toggled on every latch pulse
         data_o = ~data_o;
         pulse();
      end
   endtask : send_word
endmodule : spkcr_mcu_model

/* spkcr_pkg.sv */
package spkcr_pkg;

   // control word layout
   localparam int WORD_W       = 16;
   localparam int PAD_BIT      = 0;
   localparam int SEL_LSB      = 1;
   localparam int LATCH_PULSES = 4;

   // register selectors carried in the word
   localparam logic [1:0] SEL_PATH   = 2'h0;
   localparam logic [1:0] SEL_DUPLEX = 2'h1;
   localparam logic [1:0] SEL_NETTHR = 2'h2;
   localparam logic [1:0] SEL_TXTHR  = 2'h3;

   // field positions, path_gain_control
   localparam int MIC_BIT   = 15;
   localparam int TSD_BIT   = 14;
   localparam int GRADE_LSB = 12;
   // field positions, duplex_alloc_control
   localparam int HD_BIT    = 15;
   localparam int RSD_BIT   = 14;
   localparam int TAPS_LSB  = 12;
   // shared positions
   localparam int COEFF_LSB = 10;
   localparam int VOL_LSB   = 5;
   localparam int GAIN_LSB  = 3;

   // values after reset
   localparam logic [15:0] PATH_RST   = 16'hA080;
   localparam logic [15:0] DUPLEX_RST = 16'h2142;
   localparam logic [15:0] NETTHR_RST = 16'h0004;
   localparam logic [15:0] TXTHR_RST  = 16'h0006;

   // coefficient control codes
   localparam logic [1:0] COEFF_NORMAL = 2'h0;
   localparam logic [1:0] COEFF_CLEAR  = 2'h1;
   localparam logic [1:0] COEFF_FREEZE = 2'h2;

   // decay grading codes and tap-index shift per code
   localparam logic [1:0] GRADE_NONE = 2'h0;
   localparam logic [1:0] GRADE_FAST = 2'h1;
   localparam logic [1:0] GRADE_MID  = 2'h2;
   localparam int         SHIFT_FAST = 5;
   localparam int         SHIFT_MID  = 6;
   localparam int         SHIFT_SLOW = 7;

   // volume codes: unity (+0 dB) and mute
   localparam logic [4:0] VOL_UNITY = 5'h0A;
   localparam logic [4:0] VOL_MUTE  = 5'h1F;

   typedef logic [WORD_W-1:0] spkcr_word_t;

   typedef struct packed {
      logic       agc_en;
      logic       mute;
      logic [4:0] atten;
   } spkcr_vol_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'h1,
      RX_SHIFT = 3'h2,
      RX_LATCH = 3'h4
   } spkcr_rx_state_t;

endpackage : spkcr_pkg

/* spkcr_regs.sv */
`timescale 1ns/100ps
// Operation
// RQ1: word bits 2..1 pick which of four control registers is loaded
// RQ2: controller always sends zero in bit 0; words with bit 0 set are dropped
// RQ3: path bit 15 enables the mic preamp; resets to one
// RQ4: path bit 14 disables transmit suppression; resets to zero
// RQ5: transmit attenuates only on receive speech without near-end speech
// RQ6: path bits 13..12 pick acoustic decay grading, reset 10; network unaffected
// RQ7: graded decay gives earlier taps larger update gain, later taps smaller
// RQ8: path bits 11..10 acoustic coefficients: normal, clear, freeze, reserved
// RQ9: acoustic clear without half-duplex disable forces half-duplex
// RQ10: path bits 9..5 receive volume, 3 dB steps, 11111 mutes, reset 00100
// RQ11: volume below +0 dB is digital attenuation; above, AGC active; at +0 dB the code gives zero attenuation with AGC off
// RQ12: path bits 4..3 acoustic input gain code, reset 0 dB
// RQ13: half-duplex disable bit resets clear, howling protection active
// RQ14: receive suppression active after reset, attenuates when no far-end speech
// RQ15: tap split resets to 39.5 ms acoustic, 24 ms network
// RQ16: network input gain resets to 0 dB, same four steps
// RQ17: network coefficient control uses acoustic encoding, resets normal
// RQ18: transmit volume uses receive volume encoding, resets to +0 dB
module spkcr_regs
(
   // clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RSTN_I,
   // serial control pins
   input  wire logic        DATA_I,
   input  wire logic        STROBE_I,
   input  wire logic        DRDY_N_I,
   // speech and echo status from the signal path
   input  wire logic        RX_SPEECH_I,
   input  wire logic        NEAR_SPEECH_I,
   input  wire logic        HOWL_RISK_I,
   input  wire logic [8:0]  TAP_INDEX_I,
   // analog front end
   output logic             MIC_EN_O,
   output logic [1:0]       TX_INPUT_GAIN_O,
   output logic [1:0]       RX_INPUT_GAIN_O,
   // canceller control
   output logic [1:0]       TAP_SPLIT_O,
   output logic             ACOUSTIC_CLEAR_O,
   output logic             ACOUSTIC_FREEZE_O,
   output logic             NETWORK_CLEAR_O,
   output logic             NETWORK_FREEZE_O,
   output logic [3:0]       BETA_SHIFT_O,
   // volume
   output logic [4:0]       RX_VOLUME_O,
   output logic             RX_AGC_EN_O,
   output logic [4:0]       RX_ATTEN_O,
   output logic             RX_MUTE_O,
   output logic [4:0]       TX_VOLUME_O,
   output logic             TX_AGC_EN_O,
   output logic [4:0]       TX_ATTEN_O,
   output logic             TX_MUTE_O,
   // suppression and duplex
   output logic             TX_SUPPRESS_O,
   output logic             RX_SUPPRESS_O,
   output logic             HALF_DUPLEX_O,
   // threshold registers, raw
   output spkcr_pkg::spkcr_word_t NET_THRESH_O,
   output spkcr_pkg::spkcr_word_t TX_THRESH_O
);
   import spkcr_pkg::*;

   spkcr_word_if word_bus ();

   spkcr_word_t path_reg;
   spkcr_word_t next_path_reg;
   spkcr_word_t dup_reg;
   spkcr_word_t next_dup_reg;
   spkcr_word_t net_reg;
   spkcr_word_t next_net_reg;
   spkcr_word_t txt_reg;
   spkcr_word_t next_txt_reg;
   logic [1:0]  sel;

   spkcr_vol_t  rx_vol;
   spkcr_vol_t  next_rx_vol;
   spkcr_vol_t  tx_vol;
   spkcr_vol_t  next_tx_vol;
   logic [1:0]  acc_dec;
   logic [1:0]  next_acc_dec;
   logic [1:0]  ncc_dec;
   logic [1:0]  next_ncc_dec;
   logic [3:0]  beta;
   logic [3:0]  next_beta;
   logic        tx_supp;
   logic        next_tx_supp;
   logic        rx_supp;
   logic        next_rx_supp;
   logic        half_dup;
   logic        next_half_dup;

   // volume code to agc / mute / 3 dB attenuation steps
   function automatic spkcr_vol_t vol_decode(input logic [4:0] code);
      spkcr_vol_t v;
      v = '0;
      if (code == VOL_MUTE)
      begin
         v.mute = 1'b1;
      end
      else if (code < VOL_UNITY)
      begin
         v.agc_en = 1'b1;
      end
      else
      begin
         v.atten = 5'(code - VOL_UNITY);
      end
      return v;
   endfunction : vol_decode

   // {clear, freeze}; reserved code behaves as normal
   function automatic logic [1:0] coeff_decode(input logic [1:0] code);
      logic [1:0] d;
      d = 2'h0;
      if (code == COEFF_CLEAR)
      begin
         d = 2'h2;
      end
      else if (code == COEFF_FREEZE)
      begin
         d = 2'h1;
      end
      return d;
   endfunction : coeff_decode

   spkcr_serial_rx spkcr_serial_rx_i (
      .clk_i    (CORE_CLK_I),
      .rstn_i   (RSTN_I),
      .data_i   (DATA_I),
      .strobe_i (STROBE_I),
      .drdy_n_i (DRDY_N_I),
      .word_o   (word_bus.rx)
   );

   assign sel = word_bus.word[SEL_LSB +: 2];

   always_comb
   begin
      next_path_reg = path_reg;
      next_dup_reg  = dup_reg;
      next_net_reg  = net_reg;
      next_txt_reg  = txt_reg;
      // a set pad bit means a misframed word, so it is not stored
      if (word_bus.word_valid && !word_bus.word[PAD_BIT]) // [RQ2]
      begin
         case (sel) // [RQ1]
            SEL_PATH:   next_path_reg = word_bus.word;
            SEL_DUPLEX: next_dup_reg  = word_bus.word;
            SEL_NETTHR: next_net_reg  = word_bus.word;
            SEL_TXTHR:  next_txt_reg  = word_bus.word;
            default:    next_path_reg = path_reg;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I)
      begin
         path_reg <= PATH_RST;   // [RQ3] [RQ4] [RQ6] [RQ8] [RQ10] [RQ12]
         dup_reg  <= DUPLEX_RST; // [RQ13] [RQ14] [RQ15] [RQ16] [RQ17] [RQ18]
         net_reg  <= NETTHR_RST;
         txt_reg  <= TXTHR_RST;
      end
      else
      begin
         path_reg <= next_path_reg;
         dup_reg  <= next_dup_reg;
         net_reg  <= next_net_reg;
         txt_reg  <= next_txt_reg;
      end
   end

   always_comb
   begin
      next_rx_vol  = vol_decode(path_reg[VOL_LSB +: 5]); // [RQ10] [RQ11]
      next_tx_vol  = vol_decode(dup_reg[VOL_LSB +: 5]);  // [RQ18]
      next_acc_dec = coeff_decode(path_reg[COEFF_LSB +: 2]); // [RQ8]
      next_ncc_dec = coeff_decode(dup_reg[COEFF_LSB +: 2]);  // [RQ17]
      // later taps get a larger shift, i.e. a smaller update gain
      case (path_reg[GRADE_LSB +: 2]) // [RQ6] [RQ7]
         GRADE_NONE: next_beta = 4'h0;
         GRADE_FAST: next_beta = 4'(TAP_INDEX_I >> SHIFT_FAST);
         GRADE_MID:  next_beta = 4'(TAP_INDEX_I >> SHIFT_MID);
         default:    next_beta = 4'(TAP_INDEX_I >> SHIFT_SLOW);
      endcase
      next_tx_supp  = !path_reg[TSD_BIT] && RX_SPEECH_I && !NEAR_SPEECH_I; // [RQ4] [RQ5]
      next_rx_supp  = !dup_reg[RSD_BIT] && !RX_SPEECH_I; // [RQ14]
      next_half_dup = !dup_reg[HD_BIT]
                      && (HOWL_RISK_I || next_acc_dec[1]); // [RQ9] [RQ13]
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RSTN_I)
      begin
         rx_vol   <= '0;
         tx_vol   <= '0;
         acc_dec  <= 2'h0;
         ncc_dec  <= 2'h0;
         beta     <= 4'h0;
         tx_supp  <= 1'b0;
         rx_supp  <= 1'b0;
         half_dup <= 1'b0;
      end
      else
      begin
         rx_vol   <= next_rx_vol;
         tx_vol   <= next_tx_vol;
         acc_dec  <= next_acc_dec;
         ncc_dec  <= next_ncc_dec;
         beta     <= next_beta;
         tx_supp  <= next_tx_supp;
         rx_supp  <= next_rx_supp;
         half_dup <= next_half_dup;
      end
   end

   assign MIC_EN_O          = path_reg[MIC_BIT]; // [RQ3]
   assign TX_INPUT_GAIN_O   = path_reg[GAIN_LSB +: 2]; // [RQ12]
   assign RX_INPUT_GAIN_O   = dup_reg[GAIN_LSB +: 2];  // [RQ16]
   assign TAP_SPLIT_O       = dup_reg[TAPS_LSB +: 2];  // [RQ15]
   assign RX_VOLUME_O       = path_reg[VOL_LSB +: 5];
   assign TX_VOLUME_O       = dup_reg[VOL_LSB +: 5];
   assign ACOUSTIC_CLEAR_O  = acc_dec[1];
   assign ACOUSTIC_FREEZE_O = acc_dec[0];
   assign NETWORK_CLEAR_O   = ncc_dec[1];
   assign NETWORK_FREEZE_O  = ncc_dec[0];
   assign BETA_SHIFT_O      = beta;
   assign RX_AGC_EN_O       = rx_vol.agc_en;
   assign RX_ATTEN_O        = rx_vol.atten;
   assign RX_MUTE_O         = rx_vol.mute;
   assign TX_AGC_EN_O       = tx_vol.agc_en;
   assign TX_ATTEN_O        = tx_vol.atten;
   assign TX_MUTE_O         = tx_vol.mute;
   assign TX_SUPPRESS_O     = tx_supp;
   assign RX_SUPPRESS_O     = rx_supp;
   assign HALF_DUPLEX_O     = half_dup;
   assign NET_THRESH_O      = net_reg;
   assign TX_THRESH_O       = txt_reg;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);

   a_word_route: assert property ( // [RQ1]
      word_bus.word_valid && !word_bus.word[PAD_BIT] && sel == SEL_DUPLEX
      |=> dup_reg == $past(word_bus.word) && $stable(path_reg))
      else $error("duplex word not routed");

   a_pad_drop: assert property ( // [RQ2]
      word_bus.word_valid && word_bus.word[PAD_BIT]
      |=> $stable(path_reg) && $stable(dup_reg) && $stable(net_reg))
      else $error("word with pad bit set was stored");

   a_mic_follow: assert property ( // [RQ3]
      word_bus.word_valid && !word_bus.word[PAD_BIT] && sel == SEL_PATH
      |=> MIC_EN_O == $past(word_bus.word[MIC_BIT]))
      else $error("preamp enable does not follow written bit");

   a_tx_supp_cause: assert property ( // [RQ5]
      TX_SUPPRESS_O |-> $past(RX_SPEECH_I) && !$past(NEAR_SPEECH_I)
                        && !$past(path_reg[TSD_BIT]))
      else $error("transmit attenuation without cause");

   a_forced_half: assert property ( // [RQ9]
      path_reg[COEFF_LSB +: 2] == COEFF_CLEAR && !dup_reg[HD_BIT]
      ##1 $stable(path_reg) && $stable(dup_reg) |-> HALF_DUPLEX_O)
      else $error("half-duplex not forced by coefficient clear");

   a_rx_mute: assert property ( // [RQ10]
      path_reg[VOL_LSB +: 5] == VOL_MUTE
      |=> RX_MUTE_O && !RX_AGC_EN_O && RX_ATTEN_O == 5'h00)
      else $error("mute code not muting");

   a_rx_atten: assert property ( // [RQ11]
      path_reg[VOL_LSB +: 5] == 5'h0B
      |=> RX_ATTEN_O == 5'h01 && !RX_AGC_EN_O)
      else $error("first attenuation step wrong");

   a_beta_none: assert property ( // [RQ6]
      path_reg[GRADE_LSB +: 2] == GRADE_NONE |=> BETA_SHIFT_O == 4'h0)
      else $error("grading active with no decay");

   a_rx_supp: assert property ( // [RQ14]
      !dup_reg[RSD_BIT] && !RX_SPEECH_I |=> RX_SUPPRESS_O)
      else $error("receive suppression not applied");

   c_path_write:   cover property (word_bus.word_valid && sel == SEL_PATH);
   c_thresh_write: cover property (word_bus.word_valid && sel == SEL_TXTHR);
   c_forced_half:  cover property (ACOUSTIC_CLEAR_O && HALF_DUPLEX_O);
   c_tx_suppress:  cover property (TX_SUPPRESS_O);

endmodule : spkcr_regs

/* spkcr_regs_tb_top.sv */
`timescale 1ns/100ps
module spkcr_regs_tb_top;
   import spkcr_pkg::*;

   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        rx_speech = 1'b0;
   logic        near_speech = 1'b0;
   logic        howl_risk = 1'b0;
   logic [8:0]  tap_index = 9'h1A5;
   logic        data, strobe, drdy_n;
   logic        mic_en, ac_clear, ac_freeze, nt_clear, nt_freeze;
   logic        rx_agc, rx_mute, tx_agc, tx_mute, tx_supp, rx_supp, half_dup;
   logic [1:0]  tx_gain, rx_gain, tap_split;
   logic [3:0]  beta;
   logic [4:0]  rx_vol, rx_att, tx_vol, tx_att;
   spkcr_word_t net_thr, tx_thr;
   logic [4:0]  vols [4] = '{5'h00, 5'h0B, 5'h0A, 5'h1E};
   int          mismatches = 0;
   int          num_checks = 0;

   always #50 core_clk = ~core_clk;

   spkcr_mcu_model #(.HALF_NS(400)) spkcr_mcu_model_i (
      .data_o(data), .strobe_o(strobe), .drdy_n_o(drdy_n));

   spkcr_regs spkcr_regs_i (
      .CORE_CLK_I(core_clk), .RSTN_I(rstn), .DATA_I(data), .STROBE_I(strobe),
      .DRDY_N_I(drdy_n), .RX_SPEECH_I(rx_speech), .NEAR_SPEECH_I(near_speech),
      .HOWL_RISK_I(howl_risk), .TAP_INDEX_I(tap_index), .MIC_EN_O(mic_en),
      .TX_INPUT_GAIN_O(tx_gain), .RX_INPUT_GAIN_O(rx_gain), .TAP_SPLIT_O(tap_split),
      .ACOUSTIC_CLEAR_O(ac_clear), .ACOUSTIC_FREEZE_O(ac_freeze),
      .NETWORK_CLEAR_O(nt_clear), .NETWORK_FREEZE_O(nt_freeze), .BETA_SHIFT_O(beta),
      .RX_VOLUME_O(rx_vol), .RX_AGC_EN_O(rx_agc), .RX_ATTEN_O(rx_att),
      .RX_MUTE_O(rx_mute), .TX_VOLUME_O(tx_vol), .TX_AGC_EN_O(tx_agc),
      .TX_ATTEN_O(tx_att), .TX_MUTE_O(tx_mute), .TX_SUPPRESS_O(tx_supp),
      .RX_SUPPRESS_O(rx_supp), .HALF_DUPLEX_O(half_dup), .NET_THRESH_O(net_thr),
      .TX_THRESH_O(tx_thr));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   // decoded volume as {agc, mute, atten}
   function automatic logic [6:0] vol_exp(input logic [4:0] code);
      if (code == VOL_MUTE)
         return 7'h20;
      if (code < VOL_UNITY)
         return 7'h40;
      return {2'b00, code - VOL_UNITY};
   endfunction : vol_exp

   // register lands ~4 cycles after the last latch pulse, decode one later
   task automatic write_reg(input spkcr_word_t word);
      spkcr_mcu_model_i.send_word(word);
      repeat (6) @(negedge core_clk);
   endtask : write_reg

   task automatic set_status(input logic rx, input logic near, input logic howl);
      @(negedge core_clk);
      rx_speech = rx;
      near_speech = near;
      howl_risk = howl;
      repeat (2) @(negedge core_clk);
   endtask : set_status

   initial
   begin
      repeat (8) @(negedge core_clk);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      check(mic_en, 1'b1);
      check(tx_supp, 1'b0);
      check(rx_vol, 5'h04);
      check({rx_agc, rx_mute, rx_att}, vol_exp(5'h04));
      check({tx_gain, rx_gain}, 4'h0);
      check({ac_clear, ac_freeze, half_dup}, 3'h0);
      check(beta, 4'(tap_index >> 6));
      check(rx_supp, 1'b1);
      check(tap_split, 2'h2);
      check({nt_clear, nt_freeze}, 2'h0);
      check({tx_vol, tx_agc, tx_mute, tx_att}, {VOL_UNITY, 7'h00});
      check(net_thr, 16'h0004);
      check(tx_thr, 16'h0006);
      set_status(1'b0, 1'b0, 1'b1);
      check(half_dup, 1'b1);
      set_status(1'b1, 1'b1, 1'b0);
      check(tx_supp, 1'b0);
      set_status(1'b1, 1'b0, 1'b0);
      check(tx_supp, 1'b1);
      // sweep grade, coefficient, gain codes and volume boundaries
      for (int i = 0; i < 4; i++)
      begin
         write_reg({i[0], 1'b0, i[1:0], i[1:0], vols[i], i[1:0], SEL_PATH, 1'b0});
         check(mic_en, i[0]);
         check(tx_gain, i[1:0]);
         check(rx_vol, vols[i]);
         check({rx_agc, rx_mute, rx_att}, vol_exp(vols[i]));
         check({ac_clear, ac_freeze}, {i == 1, i == 2});
         check(beta, (i == 0) ? 4'h0 : 4'(tap_index >> (4 + i)));
         check(half_dup, i == 1);
         check(tx_supp, 1'b1);
         check({nt_clear, nt_freeze}, 2'h0);
      end
      write_reg(16'h57F8);
      check(tx_supp, 1'b0);
      check({rx_agc, rx_mute, rx_att}, 7'h20);
      check(half_dup, 1'b1);
      set_status(1'b0, 1'b0, 1'b0);
      write_reg(16'hC96A);
      check(half_dup, 1'b0);
      check(rx_supp, 1'b0);
      check(tap_split, 2'h0);
      check(rx_gain, 2'h1);
      check({nt_clear, nt_freeze}, 2'h1);
      check({tx_vol, tx_agc, tx_mute, tx_att}, {5'h0B, 7'h01});
      check(rx_vol, 5'h1F);
      write_reg(16'hABC4);
      write_reg(16'h1236);
      check(net_thr, 16'hABC4);
      check(tx_thr, 16'h1236);
      check(tx_vol, 5'h0B);
      // a word with the pad bit set must leave the bank alone
      write_reg(16'h8001);
      check(mic_en, 1'b0);
      rstn = 1'b0;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      check({mic_en, tap_split, rx_supp}, 4'hD);
      check(net_thr, 16'h0004);
      // an early tap gets a smaller shift, i.e. a larger update gain
      tap_index = 9'h07F;
      repeat (2) @(negedge core_clk);
      check(beta, 4'h1);
      finish_test();
   end

   // about 9 frames of 16 us each; far below this limit
   initial
   begin
      #1ms;
      mismatches++;
      finish_test();
   end
endmodule : spkcr_regs_tb_top

/* spkcr_serial_rx.sv */
`timescale 1ns/100ps
module spkcr_serial_rx
(
   // clock and reset
   input  wire logic  clk_i,
   input  wire logic  rstn_i,
   // serial pins, asynchronous
   input  wire logic  data_i,
   input  wire logic  strobe_i,
   input  wire logic  drdy_n_i,
   // assembled word
   spkcr_word_if.rx   word_o
);
   import spkcr_pkg::*;

   logic [2:0]      sync1;
   logic [2:0]      sync2;
   logic            strobe_prev;
   spkcr_rx_state_t state;
   spkcr_rx_state_t next_state;
   spkcr_word_t     shreg;
   spkcr_word_t     next_shreg;
   logic [1:0]      cnt;
   logic [1:0]      next_cnt;
   logic            valid;
   logic            next_valid;
   spkcr_word_t     word;
   spkcr_word_t     next_word;
   logic            rise;
   logic            drdy_n;

   // strobe is only sampled, never used as a clock
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         sync1       <= 3'h7;
         sync2       <= 3'h7;
         strobe_prev <= 1'b1;
      end
      else
      begin
         sync1       <= {data_i, strobe_i, drdy_n_i};
         sync2       <= sync1;
         strobe_prev <= sync2[1];
      end
   end

   assign rise   = sync2[1] & ~strobe_prev;
   assign drdy_n = sync2[0];

   always_comb
   begin
      next_state = state;
      next_shreg = shreg;
      next_cnt   = cnt;
      next_valid = 1'b0;
      next_word  = word;
      case (state)
         RX_IDLE, RX_SHIFT:
         begin
            if (!drdy_n)
            begin
               next_state = RX_SHIFT;
               if (rise)
               begin
                  next_shreg = {shreg[WORD_W-2:0], sync2[2]};
               end
            end
            else if (state == RX_SHIFT)
            begin
               next_state = RX_LATCH;
               next_cnt   = 2'h0;
            end
         end
         RX_LATCH:
         begin
            // transfer resumed before the latch pulses finished
            if (!drdy_n)
            begin
               next_state = RX_SHIFT;
            end
            else if (rise)
            begin
               if (cnt == 2'(LATCH_PULSES - 1))
               begin
                  next_valid = 1'b1;
                  next_word  = shreg;
                  next_state = RX_IDLE;
               end
               else
               begin
                  next_cnt = 2'(cnt + 2'h1);
               end
            end
         end
         default:
         begin
            next_state = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         state <= RX_IDLE;
         shreg <= '0;
         cnt   <= 2'h0;
         valid <= 1'b0;
         word  <= '0;
      end
      else
      begin
         state <= next_state;
         shreg <= next_shreg;
         cnt   <= next_cnt;
         valid <= next_valid;
         word  <= next_word;
      end
   end

   assign word_o.word_valid = valid;
   assign word_o.word       = word;

endmodule : spkcr_serial_rx

/* spkcr_word_if.sv */
`timescale 1ns/100ps
interface spkcr_word_if;
   import spkcr_pkg::*;
   logic        word_valid;
   spkcr_word_t word;
   modport rx   (output word_valid, output word);
   modport bank (input word_valid, input word);
endinterface : spkcr_word_if
